/* design/cef_event_flags.sv */
// event flag register and message side effects of the cec controller
`timescale 1ns/1ps

module cef_event_flags (
  input  wire  logic                       ref_clk,
  input  wire  logic                       rst,
  // avalon-mm slave
  input  wire  logic [4:0]                 avAddress,
  input  wire  logic                       avRead,
  input  wire  logic                       avWrite,
  input  wire  logic [31:0]                avWritedata,
  input  wire  logic [3:0]                 avByteenable,
  output logic       [31:0]                avReaddata,
  output logic                             avWaitrequest,
  // cec line, sensed only
  input  wire  logic                       cecLineIn,
  input  wire  cef_pkg::cef_tx_status_type txStatus,
  input  wire  cef_pkg::cef_rx_status_type rxStatus,
  input  wire  cef_pkg::cef_options_type   options,
  output cef_pkg::cef_command_type         command,
  output logic [7:0]                       rxData,
  output logic                             irq
);
  import cef_pkg::*;

  logic [FLAG_COUNT-1:0]    flags;
  logic [FLAG_COUNT-1:0]    enable;
  logic                     busAck;
  logic [2:0]               lineSync;
  logic                     lineLevel;
  logic [OWN_DELAY_LEN-1:0] ownDelay;
  logic                     txLoaded;
  logic                     retryPending;

  // line sampling: three stages, a change counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lineSync  <= 3'h7;
      lineLevel <= 1'b1;
    end else begin
      lineSync <= {lineSync[1:0], cecLineIn};
      if (lineSync[1] == lineSync[2]) begin
        lineLevel <= lineSync[2];
      end
    end
  end

  // own drive delayed to cover sync latency and slow line rise
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ownDelay <= '0;
    end else begin
      ownDelay <= {ownDelay[OWN_DELAY_LEN-2:0], txStatus.ownPullLow};
    end
  end

  wire ownPullingAny = txStatus.ownPullLow | (|ownDelay);
  wire lineForeignLow = ~lineLevel & ~ownPullingAny;

  // bus decode; one wait state, transfer completes when waitrequest is low
  wire busRequest  = avRead | avWrite;
  wire busDone     = busRequest & busAck;
  wire hitFlags    = avAddress == EVENT_FLAGS_OFS;
  wire hitEnable   = avAddress == INT_ENABLE_OFS;
  wire hitRxData   = avAddress == RX_DATA_OFS;
  wire [15:0] lowData = {avByteenable[1] ? avWritedata[15:8] : 8'h00,
                         avByteenable[0] ? avWritedata[7:0]  : 8'h00};
  wire [FLAG_COUNT-1:0] writeBits = lowData[FLAG_COUNT-1:0];
  wire flagWrite   = busDone & avWrite & hitFlags;
  wire enableWrite = busDone & avWrite & hitEnable;
  wire [FLAG_COUNT-1:0] clearMask = flagWrite ? writeBits : '0;

  function automatic logic [31:0] widen(input logic [FLAG_COUNT-1:0] v);
    widen = {{(32 - FLAG_COUNT){1'b0}}, v};
  endfunction : widen

  wire [31:0] readMux = hitFlags  ? widen(flags)  :
                        hitEnable ? widen(enable) :
                        hitRxData ? {24'h000000, rxData} : 32'h00000000;

  assign avWaitrequest = busRequest & ~busAck;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busAck     <= 1'b0;
      avReaddata <= 32'h00000000;
    end else begin
      busAck <= busRequest & ~busAck;
      if (avRead & ~busAck) begin
        avReaddata <= readMux;
      end
    end
  end

  // acknowledge polarity: broadcast expects high, singlecast expects low
  function automatic logic ackWrong(input logic isBroadcast, input logic ackLevel);
    ackWrong = isBroadcast ? ~ackLevel : ackLevel;
  endfunction : ackWrong

  // falling line seen while signal-free time is counted
  logic lineLevelDly;
  wire  lineFallSeen = lineLevelDly & ~lineLevel;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lineLevelDly <= 1'b1;
    end else begin
      lineLevelDly <= lineLevel;
    end
  end

  // transmit side events
  wire txAckWrong = ackWrong(txStatus.broadcast, txStatus.ackValue);
  wire txAckErr   = txStatus.initiatorActive & txStatus.ackSample & txAckWrong;
  // arbitration by address compare: we release, someone holds low
  wire arbAddrLoss = txStatus.initiatorActive & txStatus.arbPhase & txStatus.bitSample
                     & txStatus.ownBit & ~lineLevel;
  wire arbSftLoss  = txStatus.sftActive & lineFallSeen;
  wire arbLost     = arbAddrLoss | arbSftLoss;
  // foreign low outside address phase and follower acknowledge slot
  wire lineErr     = txStatus.initiatorActive & ~txStatus.arbPhase & ~txStatus.ackWindow
                     & lineForeignLow;
  // a load in the very cycle the slot comes due still counts
  wire txLoadNow   = txLoaded | txStatus.txDataWrite;
  wire underrun    = txStatus.initiatorActive & txStatus.byteSlotDue & ~txLoadNow;
  wire txComplete  = txStatus.initiatorActive & txStatus.msgSent & ~txAckErr;
  wire byteRequest = txStatus.initiatorActive & txStatus.fourthBitSent;
  wire txAbort     = txAckErr | lineErr | underrun;

  // transmit data slot: one load serves one slot, so a due slot always empties it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txLoaded <= 1'b0;
    end else if (txStatus.byteSlotDue | txAbort) begin
      txLoaded <= 1'b0;
    end else if (txStatus.txDataWrite) begin
      txLoaded <= 1'b1;
    end
  end

  // receive side events
  wire rxAckWrong = ackWrong(rxStatus.broadcast, rxStatus.ackValue);
  wire rxAckErr   = rxStatus.ackSample & options.listenModeOn & ~rxStatus.destOwn
                    & rxAckWrong;
  wire longErr    = rxStatus.bitTooLong;
  wire longErrBit = longErr & (rxStatus.broadcast ? ~options.broadcastNoErrbit
                                                  : options.longPeriodErrbitGen);
  wire shortErr   = rxStatus.bitTooShort;
  wire risingErr  = rxStatus.risingOutside;
  // the flag value before this cycle's clear decides the overrun
  wire overrun    = rxStatus.byteDone & flags[BYTE_RECEIVED_POS];
  wire byteTaken  = rxStatus.byteDone & ~flags[BYTE_RECEIVED_POS];
  wire rxDone     = byteTaken & rxStatus.lastByte;

  // byte kept only when it is not an overrun, so data matches the flag
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxData <= RX_DATA_RESET;
    end else if (byteTaken) begin
      rxData <= rxStatus.byteData;
    end
  end

  // flag set vector; a set in the same cycle as a clear wins
  logic [FLAG_COUNT-1:0] setBits;
  always_comb begin
    setBits                    = '0;
    setBits[BYTE_RECEIVED_POS] = byteTaken;
    setBits[RX_DONE_POS]       = rxDone;
    setBits[OVERRUN_POS]       = overrun;
    setBits[RISING_ERR_POS]    = risingErr;
    setBits[SHORT_ERR_POS]     = shortErr;
    setBits[LONG_ERR_POS]      = longErr;
    setBits[RX_ACK_ERR_POS]    = rxAckErr;
    setBits[ARB_LOST_POS]      = arbLost;
    setBits[BYTE_REQUEST_POS]  = byteRequest;
    setBits[TX_COMPLETE_POS]   = txComplete;
    setBits[UNDERRUN_POS]      = underrun;
    setBits[LINE_ERR_POS]      = lineErr;
    setBits[TX_ACK_ERR_POS]    = txAckErr;
  end

  wire [FLAG_COUNT-1:0] next_flags = (flags & ~clearMask) | setBits;
  wire [FLAG_COUNT-1:0] next_enable = enableWrite ? writeBits : enable;
  wire next_irq = |(next_flags & next_enable);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags  <= FLAGS_RESET;
      enable <= ENABLE_RESET;
      irq    <= 1'b0;
    end else begin
      flags  <= next_flags;
      enable <= next_enable;
      irq    <= next_irq;
    end
  end

  // lost arbitration: receive the winner's message, then retry
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      retryPending <= 1'b0;
    end else if (arbLost) begin
      retryPending <= 1'b1;
    end else if (txComplete | txAbort) begin
      retryPending <= 1'b0;
    end
  end

  // commands to the bit engines; message bits are not cleared on arbitration loss
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      command <= '0;
    end else begin
      command.abortTx          <= txAbort;
      command.clearMessageBits <= txAbort | txComplete;
      command.stopRx           <= rxAckErr | longErr | overrun;
      command.sendErrorBit     <= longErrBit;
      command.nackReply        <= overrun;
      command.switchToRx       <= arbLost;
      command.retryPending     <= retryPending | arbLost;
    end
  end

endmodule : cef_event_flags

/* design/cef_pkg.sv */
// shared constants and carriers of the cec event flag block
package cef_pkg;

  localparam logic [4:0]  EVENT_FLAGS_OFS = 5'h10;
  localparam logic [4:0]  INT_ENABLE_OFS  = 5'h14;
  localparam logic [4:0]  RX_DATA_OFS     = 5'h0c;
  localparam logic [12:0] FLAGS_RESET     = 13'h0000;
  localparam logic [12:0] ENABLE_RESET    = 13'h0000;
  localparam logic [7:0]  RX_DATA_RESET   = 8'h00;
  localparam int          OWN_DELAY_LEN   = 4;

  localparam int BYTE_RECEIVED_POS   = 0;
  localparam int RX_DONE_POS         = 1;
  localparam int OVERRUN_POS         = 2;
  localparam int RISING_ERR_POS      = 3;
  localparam int SHORT_ERR_POS       = 4;
  localparam int LONG_ERR_POS        = 5;
  localparam int RX_ACK_ERR_POS      = 6;
  localparam int ARB_LOST_POS        = 7;
  localparam int BYTE_REQUEST_POS    = 8;
  localparam int TX_COMPLETE_POS     = 9;
  localparam int UNDERRUN_POS        = 10;
  localparam int LINE_ERR_POS        = 11;
  localparam int TX_ACK_ERR_POS      = 12;
  localparam int FLAG_COUNT          = 13;

  // status of the transmit bit engine, all on ref_clk
  typedef struct packed {
    logic initiatorActive;   // level: we own the current message
    logic sftActive;         // level: counting signal-free time
    logic arbPhase;          // level: initiator address bits going out
    logic bitSample;         // pulse: nominal sample point of a bit
    logic ownBit;            // bit value being sent
    logic ownPullLow;        // level: our driver pulls the line low
    logic ackWindow;         // level: follower may drive acknowledge
    logic ackSample;         // pulse: acknowledge bit sampled
    logic ackValue;          // sampled acknowledge level
    logic broadcast;         // level: destination is broadcast
    logic fourthBitSent;     // pulse: fourth bit of a frame sent
    logic byteSlotDue;       // pulse: next byte is needed now
    logic msgSent;           // pulse: last frame acknowledged
    logic txDataWrite;       // pulse: software loaded transmit data
  } cef_tx_status_type;

  // status of the receive bit engine, all on ref_clk
  typedef struct packed {
    logic       ackSample;      // pulse: acknowledge slot of a frame
    logic       ackValue;       // line level in acknowledge slot
    logic       broadcast;      // level: destination is broadcast
    logic       destOwn;        // level: destination matches own address
    logic       bitTooLong;     // pulse
    logic       bitTooShort;    // pulse
    logic       risingOutside;  // pulse
    logic       byteDone;       // pulse: a byte has been assembled
    logic       lastByte;       // level with byteDone: end of message
    logic [7:0] byteData;
  } cef_rx_status_type;

  typedef struct packed {
    logic listenModeOn;
    logic longPeriodErrbitGen;
    logic broadcastNoErrbit;
  } cef_options_type;

  // commands back to the bit engines, one-cycle pulses except retryPending, and abortTx and clearMessageBits while lineErr holds
  typedef struct packed {
    logic abortTx;
    logic clearMessageBits;
    logic stopRx;
    logic sendErrorBit;
    logic nackReply;
    logic switchToRx;
    logic retryPending;
  } cef_command_type;

endpackage : cef_pkg

/* verif/cef_event_flags_sva.sv */
// port-level checks of the cec event flag block
`timescale 1ns/1ps
module cef_event_flags_sva (
  input wire logic                       ref_clk,
  input wire logic                       rst,
  input wire logic                       avRead,
  input wire logic                       avWrite,
  input wire logic                       avWaitrequest,
  input wire cef_pkg::cef_tx_status_type txStatus,
  input wire cef_pkg::cef_rx_status_type rxStatus,
  input wire cef_pkg::cef_options_type   options,
  input wire cef_pkg::cef_command_type   command,
  input wire logic [7:0]                 rxData
);
  import cef_pkg::*;
  wire logic errbitWanted = rxStatus.broadcast ? !options.broadcastNoErrbit
                                               : options.longPeriodErrbitGen;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence txAckBad;
    txStatus.initiatorActive && txStatus.ackSample &&
      (txStatus.broadcast ? !txStatus.ackValue : txStatus.ackValue);
  endsequence
  sequence rxAckBad;
    rxStatus.ackSample && options.listenModeOn && !rxStatus.destOwn &&
      (rxStatus.broadcast ? !rxStatus.ackValue : rxStatus.ackValue);
  endsequence
  chk_txack_abort: assert property (txAckBad |=>
    command.abortTx && command.clearMessageBits)
    else $error("tx ack error did not abort");
  chk_tx_complete_clear: assert property (txStatus.initiatorActive && txStatus.msgSent &&
    !txStatus.ackSample |=> command.clearMessageBits)
    else $error("completion did not clear message bits");
  chk_rxack_stop: assert property (rxAckBad |=> command.stopRx)
    else $error("rx ack error did not stop reception");
  chk_long_stop: assert property (rxStatus.bitTooLong |=> command.stopRx)
    else $error("long bit did not stop reception");
  chk_long_errbit: assert property (rxStatus.bitTooLong |=>
    command.sendErrorBit == $past(errbitWanted))
    else $error("error bit choice wrong");
  chk_arb_keep: assert property (command.switchToRx |-> !command.clearMessageBits)
    else $error("arbitration loss cleared message bits");
  chk_arb_retry: assert property (command.switchToRx |-> command.retryPending)
    else $error("no retry pending after arbitration loss");
  chk_rx_hold: assert property (!$stable(rxData) |-> $past(rxStatus.byteDone))
    else $error("rx data changed without a byte");
  chk_bus_wait: assert property ((avRead || avWrite) && avWaitrequest |=> !avWaitrequest)
    else $error("bus wait longer than one cycle");
endmodule : cef_event_flags_sva

/* verif/cef_line_partner.sv */
// far cec device on the shared open-drain line
`timescale 1ns/1ps
module cef_line_partner (
  input  wire logic farPull,
  input  wire logic ownPullLow,
  output logic      cecLine
);
  // wired-and with pull-up: a released line reads high, never the last value
  always_comb cecLine = !(farPull || ownPullLow);
endmodule : cef_line_partner

/* verif/testbench.sv */
// self-checking bench of the cec event flag block
`timescale 1ns/1ps
module testbench;
  import cef_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic [4:0]        avAddress = '0;
  logic              avRead = 1'b0;
  logic              avWrite = 1'b0;
  logic [31:0]       avWritedata = '0;
  logic [31:0]       avReaddata, d;
  logic              avWaitrequest, cecLine, irq;
  logic              farPull = 1'b0;
  cef_tx_status_type txStatus = '0;
  cef_rx_status_type rxStatus = '0;
  cef_options_type   options = 3'b110;
  cef_command_type   command;
  logic [7:0]        rxData;
  int                errors = 0;
  int                cmp_count = 0;
  always #5 ref_clk = ~ref_clk;
  cef_line_partner i_far (.farPull(farPull), .ownPullLow(txStatus.ownPullLow),
    .cecLine(cecLine));
  cef_event_flags i_dut (.ref_clk(ref_clk), .rst(rst), .avAddress(avAddress),
    .avRead(avRead), .avWrite(avWrite), .avWritedata(avWritedata), .avByteenable(4'hf),
    .avReaddata(avReaddata), .avWaitrequest(avWaitrequest), .cecLineIn(cecLine),
    .txStatus(txStatus), .rxStatus(rxStatus), .options(options), .command(command),
    .rxData(rxData), .irq(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    avAddress <= a;
    avWritedata <= wd;
    avRead <= !wr;
    avWrite <= wr;
    n = 0;
    // waitrequest is looked at on rising edges only, where the slave samples too
    do begin
      @(posedge ref_clk);
      n++;
    end while (avWaitrequest && n < 50);
    if (avWaitrequest) begin
      errors++;
      summarize();
    end else begin
      d = avReaddata;
      avRead <= 1'b0;
      avWrite <= 1'b0;
    end
  endtask : bus
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(d, exp);
  endtask : rd
  task automatic irqIs(input logic e);
    @(negedge ref_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : irqIs
  // one event pulse, read flags, clear all
  task automatic ev(input logic [13:0] t, input logic [16:0] r, input logic [12:0] e);
    @(posedge ref_clk);
    txStatus <= t;
    rxStatus <= r;
    @(posedge ref_clk);
    txStatus <= '0;
    rxStatus <= '0;
    rd(EVENT_FLAGS_OFS, {19'h0, e});
    bus(1'b1, EVENT_FLAGS_OFS, 32'h1fff);
  endtask : ev
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd(EVENT_FLAGS_OFS, 32'h0);
    rd(INT_ENABLE_OFS, 32'h0);
    bus(1'b1, INT_ENABLE_OFS, 32'hffff_ffff);
    rd(INT_ENABLE_OFS, 32'h1fff);
    rd(5'h1c, 32'h0);
    ev(14'h2060, '0, 13'h1000);
    ev(14'h2050, '0, 13'h1000);
    ev(14'h2070, '0, 13'h0000);
    ev(14'h2002, '0, 13'h0200);
    ev(14'h2008, '0, 13'h0100);
    ev(14'h2004, '0, 13'h0400);
    ev(14'h0001, '0, 13'h0000);
    ev(14'h2004, '0, 13'h0000);
    ev('0, 17'h01000, 13'h0020);
    ev('0, 17'h00800, 13'h0010);
    ev('0, 17'h00400, 13'h0008);
    ev('0, 17'h18000, 13'h0040);
    ev('0, 17'h14000, 13'h0040);
    ev('0, 17'h1a000, 13'h0000);
    // listen mode off, no error bits on long periods
    options <= 3'b001;
    ev('0, 17'h18000, 13'h0000);
    ev('0, 17'h05000, 13'h0020);
    ev('0, 17'h01000, 13'h0020);
    options <= 3'b110;
    // second byte lands while the first is still unread
    @(posedge ref_clk);
    rxStatus <= 17'h003a5;
    @(posedge ref_clk);
    rxStatus <= 17'h0025a;
    @(posedge ref_clk);
    rxStatus <= '0;
    @(negedge ref_clk);
    chk({25'h0, command}, 32'h14);
    rd(EVENT_FLAGS_OFS, 32'h7);
    rd(RX_DATA_OFS, 32'ha5);
    irqIs(1'b1);
    bus(1'b1, EVENT_FLAGS_OFS, 32'h0);
    rd(EVENT_FLAGS_OFS, 32'h7);
    bus(1'b1, INT_ENABLE_OFS, 32'h0);
    irqIs(1'b0);
    bus(1'b1, INT_ENABLE_OFS, 32'h4);
    irqIs(1'b1);
    bus(1'b1, EVENT_FLAGS_OFS, 32'h4);
    rd(EVENT_FLAGS_OFS, 32'h3);
    irqIs(1'b0);
    bus(1'b1, EVENT_FLAGS_OFS, 32'h1fff);
    txStatus <= 14'h1000;
    farPull <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd(EVENT_FLAGS_OFS, 32'h80);
    txStatus <= 14'h2000;
    bus(1'b1, EVENT_FLAGS_OFS, 32'h1fff);
    repeat (8) @(posedge ref_clk);
    rd(EVENT_FLAGS_OFS, 32'h800);
    txStatus <= 14'h2800;
    bus(1'b1, EVENT_FLAGS_OFS, 32'h1fff);
    ev(14'h2e00, '0, 13'h0080);
    farPull <= 1'b0;
    @(negedge ref_clk);
    chk({25'h0, command}, 32'h01);
    summarize();
  end
endmodule : testbench
bind cef_event_flags cef_event_flags_sva i_sva (.ref_clk(ref_clk), .rst(rst),
  .avRead(avRead), .avWrite(avWrite), .avWaitrequest(avWaitrequest),
  .txStatus(txStatus), .rxStatus(rxStatus), .options(options), .command(command),
  .rxData(rxData));
